// ===== rtl/psrs_consts.vh
// constants for the pin state, reset and standby controller
`ifndef PSRS_CONSTS_VH
`define PSRS_CONSTS_VH
// operating modes
`define PSRS_MODE_1        3'h1
`define PSRS_MODE_3        3'h3
`define PSRS_MODE_5        3'h5
`define PSRS_MODE_6        3'h6
`define PSRS_MODE_7        3'h7
// power states
`define PSRS_ST_RUN        2'h0
`define PSRS_ST_RESET      2'h1
`define PSRS_ST_HWSTBY     2'h2
`define PSRS_ST_SWSTBY     2'h3
// bus states of an external access
`define PSRS_BUS_IDLE      3'h0
`define PSRS_BUS_FIRST     3'h1
`define PSRS_BUS_SECOND    3'h2
`define PSRS_BUS_THIRD     3'h3
`define PSRS_BUS_WAIT      3'h4
// port field positions
`define PSRS_PA_ADDR_LO    4
`define PSRS_PA_ADDR_PIN   7
`define PSRS_P8_PIN1       1
// minimum reset to standby lead, in system clocks
`define PSRS_RST_LEAD_CYC  10
`endif

// ===== rtl/psrs_hold_bank.v
// hold register bank that keeps pin states in software standby
`timescale 1ns/1ps
module psrs_hold_bank #(
    parameter WIDTH = 8                     // pins in the bank
) (
    input  wire             clock_in,       // system clock
    input  wire             reset_in,       // async reset, active high
    input  wire             capture_in,     // load new pin values
    input  wire [WIDTH-1:0] out_val_in,     // live output values
    input  wire [WIDTH-1:0] out_en_in,      // live output enables
    output reg  [WIDTH-1:0] held_val_out,   // frozen values
    output reg  [WIDTH-1:0] held_en_out     // frozen enables
);
    // capture while running, freeze otherwise
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            held_val_out <= {WIDTH{1'b0}};
            held_en_out  <= {WIDTH{1'b0}};
        end else if (capture_in) begin
            held_val_out <= out_val_in;
            held_en_out  <= out_en_in;
        end
    end
endmodule // psrs_hold_bank

// ===== rtl/psrs_pin_ctrl.v
// pin state, reset and standby controller: top module
// How it works
// - soft standby: inputs and address pins float, port outputs keep
// - port 9: float in reset, keep, I/O
// - port A low four: same as port 9
// - port A 6..4: address or I/O
// - port B 7, 5..0: float, keep, I/O
// - reset low makes every port input, except PA7 driven low on wide modes
// - reset forces strobes high, data floats
// - first/second state: address low half later
// - reset sampled on clock falling edge
// - wait state acts like second state
// - third state: address held to end
// - two-state area second state acts as third
// - reset output low only on watchdog reset
`timescale 1ns/1ps
`include "psrs_consts.vh"
module psrs_pin_ctrl #(
    parameter ADDR_W = 24                         // external address width
) (
    input  wire              clock_in,            // system clock, 125 MHz
    input  wire              reset_in,            // async reset, active high
    input  wire              ext_reset_in_n,      // board reset pin
    input  wire              hw_standby_in_n,     // board standby pin
    input  wire              sw_standby_in,       // core entered soft standby
    input  wire              wdt_reset_in,        // watchdog overflow reset
    input  wire [2:0]        mode_in,             // operating mode pins
    input  wire              upper_address_control_bit_in, // 1: PA6..4 I/O
    input  wire              two_state_area_in,   // current access is 2-state
    input  wire [2:0]        bus_state_in,        // core bus state
    input  wire [ADDR_W-1:0] addr_in,             // core address
    input  wire [15:0]       wdata_in,            // core write data
    input  wire              rd_in,               // core read strobe
    input  wire              wr_in,               // core write strobe
    input  wire [5:0]        p9_val_in,           // port 9 data register
    input  wire [5:0]        p9_dir_in,           // port 9 direction
    input  wire [7:0]        pa_val_in,           // port A data register
    input  wire [7:0]        pa_dir_in,           // port A direction
    input  wire [7:0]        pb_val_in,           // port B data register
    input  wire [7:0]        pb_dir_in,           // port B direction
    input  wire              p8_dir1_in,          // port 8 pin 1 direction
    output reg  [ADDR_W-1:0] addr_out,            // address pins
    output reg               addr_oe_out,         // address pin enable
    output reg  [15:0]       data_out,            // data bus out
    output reg               data_oe_out,         // data bus enable
    output reg               addr_strobe_n_out,   // address strobe
    output reg               rd_n_out,            // read strobe
    output reg               wr_n_out,            // write strobe
    output reg               strobe_oe_out,       // strobe pin enable
    output reg  [5:0]        p9_out,              // port 9 pin values
    output reg  [5:0]        p9_oe_out,           // port 9 enables
    output reg  [7:0]        pa_out,              // port A pin values
    output reg  [7:0]        pa_oe_out,           // port A enables
    output reg  [7:0]        pb_out,              // port B pin values
    output reg  [7:0]        pb_oe_out,           // port B enables
    output reg               port8_pin1_out,      // port 8 pin 1 value
    output reg               port8_pin1_oe_out,   // port 8 pin 1 enable
    output reg               reset_out_n_out,     // reset output value
    output reg               reset_out_n_oe_out,  // reset output enable
    output reg  [1:0]        power_state_out      // present power state
);
    // pin synchronisers, falling edge sampling of external reset
    reg        rst_s1_r;                          // first sync stage
    reg        rst_s2_r;                          // synced reset pin
    reg        hw_standby_in_n_s1_r;                         // first sync stage
    reg        hw_standby_in_n_s2_r;                         // synced standby pin
    reg        rst_half_r;                        // reset seen half later
    reg        held_addr_r;                       // address held for state
    reg  [1:0] pstate_r;                          // power state
    reg  [1:0] pstate_nxt;                        // next power state
    wire       ext_mode;                          // modes 1, 3, 5, 6
    wire       wide_mode;                         // modes 3, 6
    wire       rst_now;                           // reset in force
    wire [21:0] hold_val;                         // frozen pin values
    wire [21:0] hold_en;                          // frozen pin enables
    wire       pa_hi_addr;                        // PA6..4 carry address
    wire [2:0] pa_addr_bits;                      // address 23..21, pin 4 up
    // power state codes, shared with the power_state_out encoding
    localparam [1:0] ST_RUN    = `PSRS_ST_RUN;    // run or sleep
    localparam [1:0] ST_RESET  = `PSRS_ST_RESET;  // reset in force
    localparam [1:0] ST_HWSTBY = `PSRS_ST_HWSTBY; // hardware standby
    localparam [1:0] ST_SWSTBY = `PSRS_ST_SWSTBY; // software standby

    assign ext_mode  = (mode_in == `PSRS_MODE_1) || (mode_in == `PSRS_MODE_3)
                    || (mode_in == `PSRS_MODE_5) || (mode_in == `PSRS_MODE_6);
    assign wide_mode = (mode_in == `PSRS_MODE_3) || (mode_in == `PSRS_MODE_6);
    assign pa_hi_addr = wide_mode && !upper_address_control_bit_in;
    assign rst_now   = !rst_s2_r;

    // address 21 to 23 map onto pins 6 to 4, one bit per pin
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_pa_addr
            assign pa_addr_bits[g] = addr_in[23 - g];
        end
    endgenerate

    // external reset sampled on falling edge of the clock
    always @(negedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= 1'b1;
        end else begin
            rst_s1_r <= ext_reset_in_n;
            rst_s2_r <= rst_s1_r;
        end
    end

    // standby pin synchroniser
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            hw_standby_in_n_s1_r <= 1'b1;
            hw_standby_in_n_s2_r <= 1'b1;
        end else begin
            hw_standby_in_n_s1_r <= hw_standby_in_n;
            hw_standby_in_n_s2_r <= hw_standby_in_n_s1_r;
        end
    end

    // power state: standby pin wins, then reset, then soft standby
    always @* begin
        if (!hw_standby_in_n_s2_r) begin
            pstate_nxt = ST_HWSTBY;
        end else if (rst_now) begin
            pstate_nxt = ST_RESET;
        end else if (sw_standby_in) begin
            pstate_nxt = ST_SWSTBY;
        end else begin
            pstate_nxt = ST_RUN;
        end
    end

    // power state register, starts in reset
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            pstate_r <= ST_RESET;
        end else begin
            pstate_r <= pstate_nxt;
        end
    end

    // address drop timing, half a state after the reset sample
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            rst_half_r  <= 1'b1;
            held_addr_r <= 1'b0;
        end else begin
            rst_half_r <= rst_now;
            if (!rst_now) begin
                held_addr_r <= 1'b0;
            end else if (!rst_half_r) begin
                // third state, or second state of a 2-state area, holds
                held_addr_r <= (bus_state_in == `PSRS_BUS_THIRD)
                    || (two_state_area_in
                        && bus_state_in == `PSRS_BUS_SECOND);
            end else if (bus_state_in == `PSRS_BUS_IDLE) begin
                held_addr_r <= 1'b0;                 // held state finished
            end
        end
    end

    // software standby hold banks: port 9, A, B
    psrs_hold_bank #(
        .WIDTH (22)
    ) u_hold (
        .clock_in     (clock_in),
        .reset_in     (reset_in),
        .capture_in   (pstate_nxt == `PSRS_ST_RUN),
        .out_val_in   ({pb_val_in[7], pb_val_in[5:0], pa_val_in,
                        p9_val_in, 1'b0}),
        .out_en_in    ({pb_dir_in[7], pb_dir_in[5:0], pa_dir_in,
                        p9_dir_in, 1'b0}),
        .held_val_out (hold_val),
        .held_en_out  (hold_en)
    );

    // address, data and strobe pins
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            addr_out          <= {ADDR_W{1'b0}};
            addr_oe_out       <= 1'b0;
            data_out          <= 16'h0000;
            data_oe_out       <= 1'b0;
            addr_strobe_n_out <= 1'b1;
            rd_n_out          <= 1'b1;
            wr_n_out          <= 1'b1;
            strobe_oe_out     <= 1'b0;
        end else if (pstate_nxt == `PSRS_ST_RESET) begin
            // strobes high, data released at once
            addr_strobe_n_out <= 1'b1;
            rd_n_out          <= 1'b1;
            wr_n_out          <= 1'b1;
            strobe_oe_out     <= ext_mode;
            data_oe_out       <= 1'b0;
            data_out          <= 16'h0000;
            if (!held_addr_r && rst_half_r) begin
                // low half a state later, wait acts as second
                addr_out    <= {ADDR_W{1'b0}};
                addr_oe_out <= ext_mode;
            end
        end else if (pstate_nxt == `PSRS_ST_RUN) begin
            addr_out          <= addr_in;
            addr_oe_out       <= ext_mode;
            data_out          <= wdata_in;
            data_oe_out       <= ext_mode && wr_in;
            addr_strobe_n_out <= bus_state_in == `PSRS_BUS_IDLE;
            rd_n_out          <= !rd_in;
            wr_n_out          <= !wr_in;
            strobe_oe_out     <= ext_mode;
        end else begin
            // both standby modes float the bus
            addr_oe_out   <= 1'b0;
            data_oe_out   <= 1'b0;
            strobe_oe_out <= 1'b0;
        end
    end

    // general ports by power state
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            p9_out            <= 6'h00;
            p9_oe_out         <= 6'h00;
            pa_out            <= 8'h00;
            pa_oe_out         <= 8'h00;
            pb_out            <= 8'h00;
            pb_oe_out         <= 8'h00;
            port8_pin1_out    <= 1'b0;
            port8_pin1_oe_out <= 1'b0;
        end else begin
            case (pstate_nxt)
                `PSRS_ST_RESET, `PSRS_ST_HWSTBY: begin
                    // every port goes to the input state, except PA7 in reset on wide modes
                    p9_oe_out         <= 6'h00;
                    pa_oe_out         <= 8'h00;
                    pb_oe_out         <= 8'h00;
                    port8_pin1_oe_out <= 1'b0;
                    pa_out            <= 8'h00;
                    // pin 7 driven low in reset on wide modes
                    pa_oe_out[`PSRS_PA_ADDR_PIN] <=
                        wide_mode && (pstate_nxt == `PSRS_ST_RESET);
                end
                `PSRS_ST_SWSTBY: begin
                    // inputs float, outputs
                    p9_out    <= hold_val[6:1];
                    p9_oe_out <= hold_en[6:1];
                    pa_out    <= hold_val[14:7];
                    pa_oe_out <= hold_en[14:7];
                    pb_out    <= {hold_val[21], 1'b0, hold_val[20:15]};
                    pb_oe_out <= {hold_en[21], 1'b0, hold_en[20:15]};
                    if (pa_hi_addr) begin
                        pa_oe_out[6:4] <= 3'h0;
                    end
                    if (wide_mode) begin
                        pa_oe_out[`PSRS_PA_ADDR_PIN] <= 1'b0;
                    end
                    // pin 1 floats or drives high
                    port8_pin1_out    <= ext_mode && p8_dir1_in;
                    port8_pin1_oe_out <= ext_mode && p8_dir1_in;
                end
                `PSRS_ST_RUN: begin
                    p9_out    <= p9_val_in;
                    p9_oe_out <= p9_dir_in;
                    pa_out    <= pa_val_in;
                    pa_oe_out <= pa_dir_in;
                    pb_out    <= {pb_val_in[7], 1'b0, pb_val_in[5:0]};
                    pb_oe_out <= {pb_dir_in[7], 1'b0, pb_dir_in[5:0]};
                    if (pa_hi_addr) begin
                        // address 21..23 on pins 6..4
                        pa_out[6:4] <= pa_addr_bits;
                        pa_oe_out[6:4] <= 3'h7;
                    end
                    if (wide_mode) begin
                        pa_out[`PSRS_PA_ADDR_PIN]    <= addr_in[20];
                        pa_oe_out[`PSRS_PA_ADDR_PIN] <= 1'b1;
                    end
                    port8_pin1_out    <= ext_mode && p8_dir1_in;
                    port8_pin1_oe_out <= ext_mode && p8_dir1_in;
                end
                default: begin
                    p9_oe_out <= 6'h00;
                end
            endcase
        end
    end

    // reset output: low only on watchdog reset, else floating
    always @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            reset_out_n_out    <= 1'b1;
            reset_out_n_oe_out <= 1'b0;
            power_state_out    <= `PSRS_ST_RESET;
        end else begin
            reset_out_n_out    <= !wdt_reset_in;
            reset_out_n_oe_out <= wdt_reset_in;
            power_state_out    <= pstate_nxt;
        end
    end
endmodule // psrs_pin_ctrl

// ===== verification/psrs_board_model.sv
// board logic that drives the reset and standby pins
`timescale 1ns/1ps
`include "psrs_consts.vh"
module psrs_board_model (
    input  wire clock_in,          // system clock
    output reg  ext_reset_in_n,    // board reset pin
    output reg  hw_standby_in_n    // board standby pin
);
    // both pins idle high
    initial begin
        ext_reset_in_n = 1'b1;
        hw_standby_in_n = 1'b1;
    end
    // wait clocks, then move just after the edge
    task step(input integer n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    // drive the reset pin directly
    task set_reset(input reg v);
        ext_reset_in_n = v;
    endtask
    // enter standby, with a reset lead when ram is kept
    task enter_hw_standby_in_n(input reg keep);
        if (keep) begin
            ext_reset_in_n = 1'b0;
            step(`PSRS_RST_LEAD_CYC);
        end
        hw_standby_in_n = 1'b0;
        ext_reset_in_n = 1'b1;
    endtask
    // leave standby: reset leads by about 100 ns
    task leave_hw_standby_in_n;
        ext_reset_in_n = 1'b0;
        step(13);
        hw_standby_in_n = 1'b1;
        step(12);
        ext_reset_in_n = 1'b1;
    endtask
endmodule // psrs_board_model

// ===== verification/psrs_pin_ctrl_tb.sv
// self-checking bench for the pin state, reset and standby controller
`timescale 1ns/1ps
module psrs_pin_ctrl_tb;
    reg         clock_in, reset_in, sw_standby_in, wdt_reset_in, rd_in, wr_in;
    reg         upper_address_control_bit_in, two_state_area_in, p8_dir1_in;
    reg  [2:0]  mode_in, bus_state_in;
    reg  [23:0] addr_in, held;
    reg  [15:0] wdata_in;
    reg  [5:0]  p9_val_in, p9_dir_in;
    reg  [7:0]  pa_val_in, pa_dir_in, pb_val_in, pb_dir_in;
    reg  [31:0] rv, k9, kb, ka;
    reg  [67:0] note_q[$];           // select, mask, expected value
    wire        ext_reset_in_n, hw_standby_in_n, addr_oe_out, data_oe_out;
    wire        addr_strobe_n_out, rd_n_out, wr_n_out, strobe_oe_out;
    wire        port8_pin1_out, port8_pin1_oe_out;
    wire        reset_out_n_out, reset_out_n_oe_out;
    wire [23:0] addr_out;
    wire [15:0] data_out;
    wire [5:0]  p9_out, p9_oe_out;
    wire [7:0]  pa_out, pa_oe_out, pb_out, pb_oe_out;
    wire [1:0]  power_state_out;
    integer     error_cnt, n_tests, seed, i;
    psrs_pin_ctrl dut_u (.*);
    psrs_board_model board_u (.clock_in(clock_in),
        .ext_reset_in_n(ext_reset_in_n), .hw_standby_in_n(hw_standby_in_n));
    // output group picked by a select code
    function [31:0] obs(input [3:0] s);
        case (s)
            4'h0: obs = power_state_out;
            4'h1: obs = {p9_oe_out, p9_out};
            4'h2: obs = {pa_oe_out, pa_out};
            4'h3: obs = {pb_oe_out, pb_out};
            4'h4: obs = addr_out;
            4'h5: obs = {data_oe_out, addr_strobe_n_out, rd_n_out, wr_n_out};
            4'h6: obs = {port8_pin1_oe_out, port8_pin1_out};
            default: obs = {reset_out_n_oe_out, reset_out_n_out};
        endcase
    endfunction
    task step(input integer n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task note(input [3:0] s, input [31:0] m, input [31:0] e);
        note_q.push_back({s, m, e});
    endtask
    task rnd_ports;
        rv = $random(seed);
        {p9_val_in, p9_dir_in, pa_val_in, pa_dir_in} = rv[27:0];
        wdt_reset_in = rv[28];
        rv = $random(seed);
        {pb_val_in, pb_dir_in} = rv[15:0];
    endtask
    task give_verdict;
        if (error_cnt == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // compare every pending note where outputs are settled
    always @(negedge clock_in) begin : cmp_blk
        reg [67:0] n;
        while (note_q.size() > 0) begin
            n = note_q.pop_front();
            n_tests = n_tests + 1;
            if ((obs(n[67:64]) & n[63:32]) !== (n[31:0] & n[63:32])) begin
                error_cnt = error_cnt + 1;
                $display("mismatch at %0t: got %h expected %h", $time,
                    obs(n[67:64]) & n[63:32], n[31:0] & n[63:32]);
            end
        end
    end
    // free-running system clock, 8 ns period
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clock_in);
        error_cnt = error_cnt + 1;
        give_verdict;
    end
    // main sequence
    initial begin
        seed = 92;
        error_cnt = 0;
        n_tests = 0;
        reset_in = 1'b1;
        {sw_standby_in, wdt_reset_in, rd_in, wr_in, p8_dir1_in} = 5'h00;
        {upper_address_control_bit_in, two_state_area_in} = 2'h0;
        {mode_in, bus_state_in, addr_in, wdata_in} = {3'h7, 43'h0};
        {p9_val_in, p9_dir_in, pa_val_in, pa_dir_in} = 28'h0;
        {pb_val_in, pb_dir_in} = 16'h0000;
        step(5);
        reset_in = 1'b0;
        // run then soft standby, in modes 7 and 1
        for (i = 0; i < 4; i = i + 1) begin
            p8_dir1_in = i[1];
            mode_in = i[0] ? 3'h1 : 3'h7;
            rnd_ports;
            step(2);
            k9 = {p9_dir_in, p9_val_in};
            kb = {pb_dir_in & 8'hBF, pb_val_in};
            note(1, {6'h3F, p9_dir_in}, k9);
            note(2, {8'hFF, pa_dir_in}, {pa_dir_in, pa_val_in});
            note(3, {8'hFF, pb_dir_in & 8'hBF}, kb);
            note(6, 3, (i[0] && p8_dir1_in) ? 3 : 0);
            note(7, 3, {wdt_reset_in, !wdt_reset_in});
            sw_standby_in = 1'b1;
            step(3);
            rnd_ports;
            step(3);
            note(0, 3, 3);
            note(1, {6'h3F, k9[11:6]}, k9);
            note(3, {8'hFF, kb[15:8]}, kb);
            note(6, 3, (i[0] && p8_dir1_in) ? 3 : 0);
            sw_standby_in = 1'b0;
            step(2);
        end
        // mode 3 upper address on port A
        mode_in = 3'h3;
        addr_in = $random(seed);
        step(3);
        note(2, 32'hF0F0, {8'hF0, addr_in[20], addr_in[21], addr_in[22],
            addr_in[23], 4'h0});
        sw_standby_in = 1'b1;
        step(3);
        note(2, 32'hF000, 0);
        sw_standby_in = 1'b0;
        step(3);
        // mode 6 with port A pins 6..4 as I/O, pin 7 still address
        {mode_in, upper_address_control_bit_in} = {3'h6, 1'b1};
        rnd_ports;
        step(3);
        ka = {1'b1, pa_dir_in[6:0], addr_in[20], pa_val_in[6:0]};
        note(2, {8'hFF, 1'b1, ka[14:8]}, ka);
        sw_standby_in = 1'b1;
        step(3);
        note(2, {8'hFF, 1'b0, ka[14:8]}, {1'b0, ka[14:0]});
        sw_standby_in = 1'b0;
        step(3);
        // reset in first, second, third, wait and two-state second
        for (i = 0; i < 5; i = i + 1) begin
            bus_state_in = (i == 4) ? 3'h2 : i + 1;
            two_state_area_in = (i == 4);
            rnd_ports;
            {addr_in, wdata_in} = {$random(seed), $random(seed)};
            {rd_in, wr_in} = i[0] ? 2'h2 : 2'h1;
            step(2);
            board_u.set_reset(1'b0);
            step(4);
            held = (i == 2 || i == 4) ? addr_in : 24'h000000;
            addr_in = ~addr_in;
            step(2);
            note(5, 32'hF, 32'h7);
            note(1, 32'hFC0, 0);
            note(4, 32'hFFFFFF, held);
            board_u.set_reset(1'b1);
            step(3);
            {bus_state_in, rd_in, wr_in} = 5'h00;
            step(4);
        end
        // reset output with and without watchdog cause
        board_u.set_reset(1'b0);
        wdt_reset_in = 1'b1;
        step(4);
        note(7, 3, 2);
        wdt_reset_in = 1'b0;
        step(3);
        note(7, 2, 0);
        board_u.set_reset(1'b1);
        step(4);
        // hardware standby, with and without ram kept
        board_u.enter_hw_standby_in_n(1'b1);
        step(5);
        note(0, 3, 2);
        note(3, 32'hFF00, 0);
        note(2, 32'hFF00, 0);
        board_u.leave_hw_standby_in_n;
        step(6);
        note(0, 3, 0);
        board_u.enter_hw_standby_in_n(1'b0);
        step(5);
        note(1, 32'hFC0, 0);
        board_u.leave_hw_standby_in_n;
        step(6);
        give_verdict;
    end
endmodule // psrs_pin_ctrl_tb

// ===== verification/psrs_pin_monitor.sv
// port assertions for the pin state, reset and standby controller
`timescale 1ns/1ps
module psrs_pin_monitor #(
    parameter ADDR_W = 24                 // external address width
) (
    input wire              clock_in, reset_in, ext_reset_in_n,
    input wire              hw_standby_in_n, wdt_reset_in, p8_dir1_in,
    input wire              upper_address_control_bit_in, two_state_area_in,
    input wire [2:0]        mode_in, bus_state_in,
    input wire [ADDR_W-1:0] addr_in, addr_out,
    input wire              data_oe_out, addr_strobe_n_out,
    input wire              rd_n_out, wr_n_out,
    input wire [5:0]        p9_out, p9_oe_out,
    input wire [7:0]        pa_out, pa_oe_out, pb_out, pb_oe_out,
    input wire              port8_pin1_out, port8_pin1_oe_out,
    input wire              reset_out_n_out, reset_out_n_oe_out,
    input wire [1:0]        power_state_out
);
    reg [ADDR_W-1:0] addr_q;              // core address one clock back
    // delayed address for the port A address pins
    always @(posedge clock_in) begin
        addr_q <= addr_in;
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    a_reset_ports_in:
    assert property ($fell(ext_reset_in_n) && hw_standby_in_n |-> ##[1:4]
        (p9_oe_out == 6'h00 && pb_oe_out == 8'h00 && !data_oe_out))
    else $error("ports still driven after reset pin fell");
    a_strobes_go_high:
    assert property ($fell(ext_reset_in_n) && hw_standby_in_n |-> ##[1:4]
        (addr_strobe_n_out && rd_n_out && wr_n_out))
    else $error("strobes not high after reset pin fell");
    a_early_addr_low:
    assert property ($fell(ext_reset_in_n) && hw_standby_in_n &&
        (bus_state_in == 3'h1 || bus_state_in == 3'h4 ||
        (bus_state_in == 3'h2 && !two_state_area_in)) |-> ##[2:5]
        addr_out == '0)
    else $error("address not low after reset in early state");
    a_late_addr_held:
    assert property (!ext_reset_in_n && !$past(ext_reset_in_n, 3) &&
        (bus_state_in == 3'h3 || (bus_state_in == 3'h2 && two_state_area_in))
        |=> $stable(addr_out))
    else $error("address moved after reset in last state");
    a_swstby_keeps_pins:
    assert property (power_state_out == 2'h3 && $past(power_state_out) == 2'h3
        |-> $stable(p9_out) && $stable(p9_oe_out) && $stable(pb_out) &&
        $stable(pb_oe_out))
    else $error("pins changed in soft standby");
    a_hwstby_all_float:
    assert property (!hw_standby_in_n [*5] |-> p9_oe_out == 6'h00 &&
        pa_oe_out == 8'h00 && pb_oe_out == 8'h00 && !port8_pin1_oe_out)
    else $error("pin driven in hardware standby");
    a_pa_addr_pins:
    assert property (power_state_out == 2'h0 && $past(power_state_out) == 2'h0
        && $past(mode_in) == 3'h3 && !$past(upper_address_control_bit_in) |->
        pa_oe_out[7:4] == 4'hF && pa_out[7:4] ==
        {addr_q[20], addr_q[21], addr_q[22], addr_q[23]})
    else $error("port A upper pins do not carry the address");
    a_p8_pin_high:
    assert property ((power_state_out == 2'h0 || power_state_out == 2'h3) &&
        $past(power_state_out) == power_state_out && $past(p8_dir1_in) &&
        ($past(mode_in) == 3'h1 || $past(mode_in) == 3'h3 ||
        $past(mode_in) == 3'h5 || $past(mode_in) == 3'h6) |->
        port8_pin1_oe_out && port8_pin1_out)
    else $error("port 8 pin 1 not driven high");
    a_wdt_drives_low:
    assert property ((wdt_reset_in && hw_standby_in_n) [*2] |=>
        reset_out_n_oe_out && !reset_out_n_out)
    else $error("reset output not low on watchdog reset");
    a_reset_out_float:
    assert property ((!wdt_reset_in && power_state_out == 2'h1) [*2] |=>
        !reset_out_n_oe_out)
    else $error("reset output driven without watchdog cause");
endmodule // psrs_pin_monitor
bind psrs_pin_ctrl psrs_pin_monitor #(.ADDR_W(ADDR_W)) mon_u (.*);
